// ---- shared/smcm_pkg.sv ----
/*
  smcm_pkg: shared constants, register map, field layouts and carrier types for the
  safety master connection manager.
  Assumes a 100 MHz controller clock and a byte-addressed 12-bit register port.
*/
`default_nettype none
package smcm_pkg;
  // ==========================================================================
  // sizes
  localparam int NCONN_MAX = 32;                 // later revision
  localparam int NCONN_OLD = 16;                 // earlier revision
  localparam int IDX_W = 5;
  localparam int PAYLOAD_BYTES = 16;
  localparam int PAYLOAD_W = PAYLOAD_BYTES * 8;
  localparam int EPI_W = 16;
  localparam logic [4:0] PAYLOAD_MAX_LEN = 5'h10;
  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;                 // one millisecond timebase
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [EPI_W-1:0] SLAVE_CYCLE_MS = 16'h0006;
  localparam logic [EPI_W-1:0] CYCLE_RST = 16'h0006;
  localparam logic [7:0] OPEN_WAIT_MS = 8'h64;   // wait for an open answer
  // ==========================================================================
  // register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CYCLE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_MASK = 12'h00c;
  localparam logic [11:0] ADDR_RESTART = 12'h010;
  localparam logic [11:0] ADDR_ESTAB = 12'h014;
  localparam logic [11:0] ADDR_STOPPED = 12'h018;
  localparam logic [11:0] ADDR_REJECT = 12'h01c;
  localparam logic [3:0] REGION_GLOBAL = 4'h0;
  localparam logic [3:0] REGION_CFG = 4'h1;
  localparam logic [3:0] REGION_SIG = 4'h2;
  localparam logic [2:0] REGION_IOMEM = 3'h2;    // addr[11:9]
  // ==========================================================================
  // control and status fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_REV = 1;
  localparam int CTRL_POL_LSB = 2;
  localparam int STAT_W = 4;
  localparam int STAT_TIMEOUT = 0;
  localparam int STAT_REJECT = 1;
  localparam int STAT_OPENED = 2;
  localparam int STAT_SIGBAD = 3;

  typedef enum logic [1:0] {
    OPEN_CONFIGURE = 2'h0,
    OPEN_SIGNATURE = 2'h1,
    OPEN_ONLY = 2'h2
  } smcm_open_t;

  typedef enum logic [1:0] {
    POLICY_AUTO = 2'h0,
    POLICY_STOP_ONE = 2'h1,
    POLICY_STOP_ALL = 2'h2
  } smcm_policy_t;

  // connection settings word
  typedef struct packed {
    logic [EPI_W-1:0] data_arrival_period;
    logic [6:0] rsvd;
    logic [3:0] assembly;
    logic is_input;
    logic mcast;
    smcm_open_t open_type;
    logic enable;
  } smcm_cfg_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    smcm_open_t open_type;
    logic send_config;
    logic check_sig;
    logic mcast;
    logic [3:0] assembly;
    logic [EPI_W-1:0] data_arrival_period;
    logic [15:0] signature;
  } smcm_open_req_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic accept;
    logic [15:0] signature;
  } smcm_open_rsp_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [3:0] assembly;
    logic [4:0] len;
    logic [PAYLOAD_W-1:0] data;
  } smcm_rx_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [PAYLOAD_W-1:0] data;
  } smcm_tx_t;
endpackage
`default_nettype wire

// ---- hdl/smcm_conn_mgr.sv ----
/*
  smcm_conn_mgr: opens, supervises and closes safety I/O connections of a safety master.
  Assumes the network side is logic on the same clock that answers open requests and
  delivers received packets as one-cycle valid structs.
*/
// Functional notes
// R01: 16 connections old revision, 32 new
// R02: payload at most sixteen bytes per connection
// R03: each connection single-cast or multicast
// R04: configure type sends slave configuration on open
// R05: signature type compares slave signature on open
// R06: open-only type opens without any check; code still applies the R01, R07 and R14 checks before opening
// R07: multicast allowed only for input slaves
// R08: slave multicasts to at most fifteen masters
// R09: same assembly and interval form one group
// R10: multicast allowed with a single master
// R11: single-cast is one master, one slave
// R12: transmitter supervised to send within interval
// R13: no data in interval: drop, safe state
// R14: interval below max(cycle, 6 ms) rejected
// R15: only the selected assembly is exchanged
// R16: slave data placed in own I/O memory
// R17: timeout policy: recover, stop one, stop all
// R18: restart on flag rise; stop-all restarts all
`timescale 1ns/100ps
`default_nettype none
module smcm_conn_mgr #(
  parameter int unsigned TICK_CYCLES = smcm_pkg::TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [smcm_pkg::ADDR_W-1:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_we_in,
  input wire logic bus_re_in,
  output logic [31:0] bus_rdata_out,
  input wire smcm_pkg::smcm_open_rsp_t open_rsp_in,
  input wire smcm_pkg::smcm_rx_t rx_in,
  output var smcm_pkg::smcm_open_req_t open_req_out,
  output var smcm_pkg::smcm_tx_t tx_out,
  output logic [31:0] safe_state_out,
  output logic irq_out
);
  localparam int N = smcm_pkg::NCONN_MAX;

  // ==========================================================================
  // helper functions
  // lowest set bit of a connection vector
  function automatic logic [smcm_pkg::IDX_W-1:0] first_set(input logic [N-1:0] v);
    logic [smcm_pkg::IDX_W-1:0] r;
    r = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = k[smcm_pkg::IDX_W-1:0];
      end
    end
    return r;
  endfunction

  // connection index allowed by the selected revision
  function automatic logic idx_ok(input logic [smcm_pkg::IDX_W-1:0] i, input logic rev_new);
    return rev_new | (i < smcm_pkg::IDX_W'(smcm_pkg::NCONN_OLD));
  endfunction

  // ==========================================================================
  // registers
  logic [31:0] ctrl_reg;
  logic [smcm_pkg::EPI_W-1:0] cycle_reg;
  logic [smcm_pkg::STAT_W-1:0] status_reg, mask_reg;
  logic [N-1:0] restart_reg, restart_prev_reg;
  logic [N-1:0] estab_reg, stopped_reg, reject_reg;
  smcm_pkg::smcm_cfg_t cfg_reg [N];
  logic [15:0] sig_reg [N];
  logic [smcm_pkg::PAYLOAD_W-1:0] iomem_reg [N];
  logic [31:0] rdata_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;

  typedef enum {S_IDLE, S_CHECK, S_OPEN, S_WAIT} smcm_state_t;
  smcm_state_t state_reg;
  logic [smcm_pkg::IDX_W-1:0] ptr_reg;
  logic [7:0] wait_cnt_reg;

  smcm_pkg::smcm_policy_t policy;
  logic run, rev_new;
  logic [smcm_pkg::EPI_W-1:0] min_epi;
  smcm_pkg::smcm_cfg_t cur;
  logic need_open, chk_bad, rsp_hit, open_ok, sig_bad;
  logic [N-1:0] en_vec, tmo_vec, rx_ok, tx_due, tx_grant, ptr_hot;
  logic [smcm_pkg::IDX_W-1:0] tx_idx;

  // address decode strobes
  logic wr_global, wr_cfg, wr_sig, wr_iomem;
  logic [smcm_pkg::IDX_W-1:0] wr_cfg_idx, wr_mem_idx;
  logic [1:0] wr_word;

  assign policy = smcm_pkg::smcm_policy_t'(ctrl_reg[smcm_pkg::CTRL_POL_LSB +: 2]);
  assign run = ctrl_reg[smcm_pkg::CTRL_RUN];
  assign rev_new = ctrl_reg[smcm_pkg::CTRL_REV];
  assign wr_global = bus_we_in & (bus_addr_in[11:8] == smcm_pkg::REGION_GLOBAL);
  assign wr_cfg = bus_we_in & (bus_addr_in[11:8] == smcm_pkg::REGION_CFG);
  assign wr_sig = bus_we_in & (bus_addr_in[11:8] == smcm_pkg::REGION_SIG);
  assign wr_iomem = bus_we_in & (bus_addr_in[11:9] == smcm_pkg::REGION_IOMEM);
  assign wr_cfg_idx = bus_addr_in[6:2];
  assign wr_mem_idx = bus_addr_in[8:4];
  assign wr_word = bus_addr_in[3:2];

  // ==========================================================================
  // millisecond timebase
  always_ff @(posedge clock_in) begin
    if (!rstn_in || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == TICK_CYCLES - 1);

  // ==========================================================================
  // software registers
  // global control, cycle time, mask, restart flags
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ctrl_reg <= '0;
      cycle_reg <= smcm_pkg::CYCLE_RST;
      mask_reg <= '0;
      restart_reg <= '0;
    end else if (wr_global) begin
      case (bus_addr_in)
        smcm_pkg::ADDR_CTRL: ctrl_reg <= {28'h0, bus_wdata_in[3:0]};
        smcm_pkg::ADDR_CYCLE: cycle_reg <= bus_wdata_in[smcm_pkg::EPI_W-1:0];
        smcm_pkg::ADDR_MASK: mask_reg <= bus_wdata_in[smcm_pkg::STAT_W-1:0];
        smcm_pkg::ADDR_RESTART: restart_reg <= bus_wdata_in;
        default: ;
      endcase
    end
  end

  // connection settings and expected signatures
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < N; i++) begin
        cfg_reg[i] <= '0;
        sig_reg[i] <= '0;
      end
    end else if (wr_cfg) begin
      cfg_reg[wr_cfg_idx] <= {bus_wdata_in[31:16], 7'h00, bus_wdata_in[8:0]};
    end else if (wr_sig) begin
      sig_reg[wr_cfg_idx] <= bus_wdata_in[15:0];
    end
  end

  // ==========================================================================
  // open sequencer: scans connections and opens them one at a time
  assign cur = cfg_reg[ptr_reg];
  assign min_epi = (cycle_reg > smcm_pkg::SLAVE_CYCLE_MS) ? cycle_reg : smcm_pkg::SLAVE_CYCLE_MS;
  assign need_open = cur.enable & ~estab_reg[ptr_reg] & ~stopped_reg[ptr_reg] & ~reject_reg[ptr_reg];
  assign chk_bad = (state_reg == S_CHECK) & (~idx_ok(ptr_reg, rev_new) // R01
                 | (cur.mcast & ~cur.is_input) // R07
                 | (cur.data_arrival_period < min_epi) // R14
                 | (cur.open_type == 2'h3));
  assign rsp_hit = (state_reg == S_WAIT) & open_rsp_in.valid & (open_rsp_in.idx == ptr_reg);
  assign sig_bad = rsp_hit & open_rsp_in.accept & (cur.open_type == smcm_pkg::OPEN_SIGNATURE)
                 & (open_rsp_in.signature != sig_reg[ptr_reg]); // R05
  assign open_ok = rsp_hit & open_rsp_in.accept & cur.enable & ~sig_bad; // R06
  assign ptr_hot = N'(1) << ptr_reg;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state_reg <= S_IDLE;
      ptr_reg <= '0;
      wait_cnt_reg <= '0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (run && need_open) begin
            state_reg <= S_CHECK;
          end else begin
            ptr_reg <= ptr_reg + 5'h01;
          end
        end
        S_CHECK: begin
          if (chk_bad) begin
            state_reg <= S_IDLE;
            ptr_reg <= ptr_reg + 5'h01;
          end else begin
            state_reg <= S_OPEN;
          end
        end
        S_OPEN: begin
          state_reg <= S_WAIT;
          wait_cnt_reg <= '0;
        end
        S_WAIT: begin
          if (rsp_hit || (tick && wait_cnt_reg == smcm_pkg::OPEN_WAIT_MS - 8'h01)) begin
            state_reg <= S_IDLE;
            ptr_reg <= ptr_reg + 5'h01;
          end else if (tick) begin
            wait_cnt_reg <= wait_cnt_reg + 8'h01;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // open request, carrying the group key (assembly, interval) for multicast
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      open_req_out <= '0;
    end else begin
      open_req_out.valid <= (state_reg == S_CHECK) & ~chk_bad;
      open_req_out.idx <= ptr_reg;
      open_req_out.open_type <= cur.open_type;
      open_req_out.send_config <= (cur.open_type == smcm_pkg::OPEN_CONFIGURE); // R04
      open_req_out.check_sig <= (cur.open_type == smcm_pkg::OPEN_SIGNATURE); // R05
      open_req_out.mcast <= cur.mcast; // R03 R10 R11
      open_req_out.assembly <= cur.assembly; // R09 R15
      open_req_out.data_arrival_period <= cur.data_arrival_period; // R09
      open_req_out.signature <= sig_reg[ptr_reg]; // R04
    end
  end

  // ==========================================================================
  // connection state: established, rejected, stopped
  always_ff @(posedge clock_in) begin
    if (!rstn_in || !run) begin
      estab_reg <= '0;
    end else begin
      estab_reg <= (estab_reg | (open_ok ? ptr_hot : '0)) & ~tmo_vec & en_vec; // R13
    end
  end

  // rejection set wins over the clear from a settings rewrite
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      reject_reg <= '0;
    end else begin
      reject_reg <= (reject_reg & ~(wr_cfg ? (N'(1) << wr_cfg_idx) : '0))
                  | ((chk_bad | sig_bad) ? ptr_hot : '0);
    end
  end

  // post-timeout policy and restart by rising restart flags
  always_ff @(posedge clock_in) begin
    restart_prev_reg <= rstn_in ? restart_reg : '0;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      stopped_reg <= '0;
    end else begin
      case (policy)
        smcm_pkg::POLICY_STOP_ONE: begin
          stopped_reg <= (stopped_reg & ~(restart_reg & ~restart_prev_reg)) | tmo_vec; // R17 R18
        end
        smcm_pkg::POLICY_STOP_ALL: begin
          if (|tmo_vec) begin
            stopped_reg <= en_vec; // R17
          end else if ((&(restart_reg | ~en_vec)) && !(&(restart_prev_reg | ~en_vec))) begin
            stopped_reg <= '0; // R18
          end
        end
        default: stopped_reg <= '0; // R17
      endcase
    end
  end

  // ==========================================================================
  // per-connection supervision timers
  assign rx_ok = (rx_in.valid && idx_ok(rx_in.idx, rev_new) && estab_reg[rx_in.idx]
                 && (rx_in.assembly == cfg_reg[rx_in.idx].assembly) // R15
                 && (rx_in.len <= smcm_pkg::PAYLOAD_MAX_LEN)) // R02
               ? (N'(1) << rx_in.idx) : '0;

  generate
    for (genvar g = 0; g < N; g++) begin : g_conn
      logic [smcm_pkg::EPI_W-1:0] arr_cnt_reg, tx_cnt_reg;
      assign en_vec[g] = cfg_reg[g].enable & idx_ok(smcm_pkg::IDX_W'(g), rev_new); // R01
      assign tmo_vec[g] = estab_reg[g] & ~rx_ok[g] & (arr_cnt_reg >= cfg_reg[g].data_arrival_period); // R13
      assign tx_due[g] = estab_reg[g] & ~cfg_reg[g].is_input
                       & (tx_cnt_reg >= (cfg_reg[g].data_arrival_period >> 1)); // R12

      // arrival timer, restarted by every valid packet
      always_ff @(posedge clock_in) begin
        if (!rstn_in || !estab_reg[g] || rx_ok[g]) begin
          arr_cnt_reg <= '0; // R12
        end else if (tick && arr_cnt_reg != 16'hffff) begin
          arr_cnt_reg <= arr_cnt_reg + 16'h0001;
        end
      end

      // transmit timer, sends twice per interval to stay inside it
      always_ff @(posedge clock_in) begin
        if (!rstn_in || !estab_reg[g] || tx_grant[g]) begin
          tx_cnt_reg <= '0; // R12
        end else if (tick && tx_cnt_reg != 16'hffff) begin
          tx_cnt_reg <= tx_cnt_reg + 16'h0001;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // I/O memory: input slaves land here, output slaves are sent from here
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < N; i++) begin
        iomem_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (tmo_vec[i]) begin
          iomem_reg[i] <= '0; // R13
        end else if (rx_ok[i] && cfg_reg[i].is_input) begin
          for (int b = 0; b < smcm_pkg::PAYLOAD_BYTES; b++) begin
            iomem_reg[i][b*8 +: 8] <= (b < rx_in.len) ? rx_in.data[b*8 +: 8] : 8'h00; // R16
          end
        end else if (wr_iomem && wr_mem_idx == i[smcm_pkg::IDX_W-1:0] && !cfg_reg[i].is_input) begin
          iomem_reg[i][wr_word*32 +: 32] <= bus_wdata_in;
        end
      end
    end
  end

  // transmit arbiter, lowest due connection first
  assign tx_idx = first_set(tx_due);
  assign tx_grant = (|tx_due) ? (N'(1) << tx_idx) : '0;
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      tx_out <= '0;
    end else begin
      tx_out.valid <= |tx_due; // R11
      tx_out.idx <= tx_idx;
      tx_out.data <= iomem_reg[tx_idx];
    end
  end

  // ==========================================================================
  // events, interrupt and safe-state flags
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~((wr_global && bus_addr_in == smcm_pkg::ADDR_STATUS)
                    ? bus_wdata_in[smcm_pkg::STAT_W-1:0] : '0))
                  | {sig_bad, open_ok, chk_bad | sig_bad, |tmo_vec};
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
      safe_state_out <= '0;
    end else begin
      irq_out <= |(status_reg & mask_reg);
      safe_state_out <= en_vec & ~estab_reg; // R13
    end
  end

  // ==========================================================================
  // register read port, data one cycle after the strobe
  always_comb begin
    rdata_reg = '0;
    if (bus_addr_in[11:8] == smcm_pkg::REGION_GLOBAL) begin
      case (bus_addr_in)
        smcm_pkg::ADDR_CTRL: rdata_reg = ctrl_reg;
        smcm_pkg::ADDR_CYCLE: rdata_reg = {16'h0000, cycle_reg};
        smcm_pkg::ADDR_STATUS: rdata_reg = {28'h0, status_reg};
        smcm_pkg::ADDR_MASK: rdata_reg = {28'h0, mask_reg};
        smcm_pkg::ADDR_RESTART: rdata_reg = restart_reg;
        smcm_pkg::ADDR_ESTAB: rdata_reg = estab_reg;
        smcm_pkg::ADDR_STOPPED: rdata_reg = stopped_reg;
        smcm_pkg::ADDR_REJECT: rdata_reg = reject_reg;
        default: rdata_reg = '0;
      endcase
    end else if (bus_addr_in[11:8] == smcm_pkg::REGION_CFG) begin
      rdata_reg = cfg_reg[bus_addr_in[6:2]];
    end else if (bus_addr_in[11:8] == smcm_pkg::REGION_SIG) begin
      rdata_reg = {16'h0000, sig_reg[bus_addr_in[6:2]]};
    end else if (bus_addr_in[11:9] == smcm_pkg::REGION_IOMEM) begin
      rdata_reg = iomem_reg[bus_addr_in[8:4]][bus_addr_in[3:2]*32 +: 32];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      bus_rdata_out <= '0;
    end else begin
      bus_rdata_out <= bus_re_in ? rdata_reg : '0;
    end
  end

  // ==========================================================================
  // assertions
  a_req_limit: assert property (@(posedge clock_in) disable iff (!rstn_in)
    open_req_out.valid |-> idx_ok(open_req_out.idx, rev_new)) // R01
    else $error("open request beyond connection limit");
  a_mcast_input: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state_reg == S_CHECK && cur.mcast && !cur.is_input) |=> reject_reg[$past(ptr_reg)]
      && !open_req_out.valid) // R07
    else $error("multicast to non-input slave not rejected");
  a_epi_floor: assert property (@(posedge clock_in) disable iff (!rstn_in)
    open_req_out.valid |-> open_req_out.data_arrival_period >= $past(min_epi)) // R14
    else $error("interval below floor was opened");
  a_open_flags: assert property (@(posedge clock_in) disable iff (!rstn_in)
    open_req_out.valid |-> (open_req_out.send_config == (open_req_out.open_type == smcm_pkg::OPEN_CONFIGURE))
      && (open_req_out.check_sig == (open_req_out.open_type == smcm_pkg::OPEN_SIGNATURE))) // R04
    else $error("open flags disagree with open type");
  a_sig_mismatch: assert property (@(posedge clock_in) disable iff (!rstn_in)
    sig_bad |=> !estab_reg[$past(ptr_reg)] && status_reg[smcm_pkg::STAT_SIGBAD]) // R05
    else $error("signature mismatch still opened");
  a_timeout_drop: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (|tmo_vec) |=> ((estab_reg & $past(tmo_vec)) == '0) ##1 ((safe_state_out & $past(tmo_vec, 2)) != '0)) // R13
    else $error("timed out connection not dropped to safe state");
  a_stop_one: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (policy == smcm_pkg::POLICY_STOP_ONE && |tmo_vec) |=> ((stopped_reg & $past(tmo_vec)) == $past(tmo_vec))) // R17
    else $error("timed out connection not stopped");
  a_stop_all: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (policy == smcm_pkg::POLICY_STOP_ALL && |tmo_vec) |=> stopped_reg == $past(en_vec)) // R17
    else $error("stop-all did not stop all");
  a_tx_estab: assert property (@(posedge clock_in) disable iff (!rstn_in)
    tx_out.valid |-> |($past(estab_reg) & (N'(1) << tx_out.idx))) // R12
    else $error("data sent on closed connection");
  a_rx_place: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (rx_ok[rx_in.idx] && cfg_reg[rx_in.idx].is_input && !tmo_vec[rx_in.idx] && rx_in.len == 5'h10)
      |=> iomem_reg[$past(rx_in.idx)] == $past(rx_in.data)) // R16
    else $error("received data not placed in memory");

  c_open: cover property (@(posedge clock_in) disable iff (!rstn_in) open_ok);
  c_timeout: cover property (@(posedge clock_in) disable iff (!rstn_in) |tmo_vec);
  c_reject: cover property (@(posedge clock_in) disable iff (!rstn_in) chk_bad);
  c_tx: cover property (@(posedge clock_in) disable iff (!rstn_in) tx_out.valid);
endmodule // smcm_conn_mgr
`default_nettype wire

// ---- testbench/smcm_slave_model.sv ----
/*
  smcm_slave_model: behavioural safety input slave on the far side of the manager.
  Assumes the manager's clock; answers each open one cycle later and then streams data.
*/
`timescale 1ns/100ps
`default_nettype none
module smcm_slave_model (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire smcm_pkg::smcm_open_req_t req_in,
  input wire logic quiet_in,
  output var smcm_pkg::smcm_open_rsp_t rsp_out,
  output var smcm_pkg::smcm_rx_t rx_out
);
  logic [7:0] cnt_reg;
  logic [31:0] up_reg;
  // ==========================================================================
  // open answer, then data for every opened connection in turn
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      cnt_reg <= 8'h00;
      up_reg <= 32'h0;
      rsp_out <= '0;
      rx_out <= '0;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      if (req_in.valid) begin
        rsp_out <= {1'b1, req_in.idx, 1'b1, 16'h5a3c};
        up_reg[req_in.idx] <= 1'b1;
      end else begin
        rsp_out <= '0;
      end
      // one connection per cycle: each is served every 32 cycles
      if (up_reg[cnt_reg[4:0]] && !quiet_in) begin
        rx_out <= {1'b1, cnt_reg[4:0], 4'h2, 5'h10, {16{8'ha5}}};
      end else begin
        rx_out <= {15'h0, {16{cnt_reg}}}; // idle data keeps changing
      end
    end
  end
endmodule // smcm_slave_model
`default_nettype wire

// ---- testbench/tb.sv ----
/*
  tb: self-checking bench of the connection manager with one slave model.
  Assumes a 1 ms tick shortened to 10 clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [11:0] bus_addr_in = 12'h000;
  logic [31:0] bus_wdata_in = 32'h0;
  logic bus_we_in = 1'b0;
  logic bus_re_in = 1'b0;
  logic quiet = 1'b0;
  logic [31:0] bus_rdata_out;
  logic [31:0] safe_state_out;
  logic irq_out;
  logic [2:0] req_kind [32];
  logic [31:0] tx_word = 32'h0;
  int err_total = 0;
  int total_checks = 0;
  smcm_pkg::smcm_open_rsp_t rsp;
  smcm_pkg::smcm_rx_t rx;
  smcm_pkg::smcm_open_req_t req;
  smcm_pkg::smcm_tx_t tx;
  localparam logic [43:0] ROWS [8] = '{44'h000_00000000, 44'h004_00000006,
    44'h008_00000000, 44'h00c_00000000, 44'h014_00000000, 44'h018_00000000,
    44'h01c_00000000, 44'h020_00000000};
  smcm_conn_mgr #(.TICK_CYCLES(10)) dut (.clock_in(clock_in), .rstn_in(rstn_in),
    .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_we_in(bus_we_in),
    .bus_re_in(bus_re_in), .bus_rdata_out(bus_rdata_out), .open_rsp_in(rsp), .rx_in(rx),
    .open_req_out(req), .tx_out(tx), .safe_state_out(safe_state_out), .irq_out(irq_out));
  smcm_slave_model slave (.clock_in(clock_in), .rstn_in(rstn_in), .req_in(req),
    .quiet_in(quiet), .rsp_out(rsp), .rx_out(rx));
  // ==========================================================================
  // clock and open request monitor
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (req.valid === 1'b1) req_kind[req.idx] <= {req.send_config, req.check_sig, req.mcast};
  end
  always @(posedge clock_in) begin
    if (tx.valid === 1'b1 && tx.idx == 5'h06) tx_word <= tx.data[31:0];
  end
  // ==========================================================================
  // bus and check tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus_addr_in <= a;
    bus_wdata_in <= d;
    bus_we_in <= 1'b1;
    @(posedge clock_in);
    bus_we_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    bus_addr_in <= a;
    bus_re_in <= 1'b1;
    @(posedge clock_in);
    bus_re_in <= 1'b0;
    #1 d = bus_rdata_out;
    @(posedge clock_in);
  endtask
  task automatic wait_rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    for (int n = 0; n < 400; n++) begin
      rd(a, d);
      if (d === exp) return;
    end
    check("wait", d, exp);
    tally_and_finish();
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] d;
    repeat (5) @(posedge clock_in);
    rstn_in <= 1'b1;
    foreach (ROWS[i]) begin
      rd(ROWS[i][43:32], d);
      check("reset reg", d, ROWS[i][31:0]);
    end
    wr(12'h100, 32'h00080051);
    wr(12'h104, 32'h00080053);
    wr(12'h204, 32'h00005a3c);
    wr(12'h108, 32'h00050051);
    wr(12'h10c, 32'h00080049);
    wr(12'h110, 32'h0008005d);
    wr(12'h114, 32'h00080053);
    wr(12'h214, 32'h00001234);
    wr(12'h118, 32'h00080045);
    wr(12'h460, 32'h0000c0de);
    wr(12'h00c, 32'h0000000f);
    wr(12'h000, 32'h00000003);
    wait_rd(12'h014, 32'h00000053);
    rd(12'h01c, d);
    check("reject", d, 32'h0000002c);
    rd(12'h008, d);
    check("status", d, 32'h0000000e);
    check("configure", {29'h0, req_kind[0]}, 32'h4);
    check("signature", {29'h0, req_kind[1]}, 32'h2);
    check("open only", {29'h0, req_kind[4]}, 32'h1);
    check("irq", {31'h0, irq_out}, 32'h1);
    repeat (40) @(posedge clock_in);
    rd(12'h400, d);
    check("io memory", d, 32'ha5a5a5a5);
    wr(12'h000, 32'h00000007);
    quiet <= 1'b1;
    wait_rd(12'h018, 32'h00000053);
    check("safe state", safe_state_out & 32'h53, 32'h53);
    check("tx data", tx_word, 32'h0000c0de);
    rd(12'h400, d);
    check("io cleared", d, 32'h0);
    quiet <= 1'b0;
    wr(12'h010, 32'h00000001);
    wait_rd(12'h014, 32'h00000001);
    rd(12'h018, d);
    check("stopped", d, 32'h00000052);
    wr(12'h000, 32'h0000000b);
    quiet <= 1'b1;
    wait_rd(12'h018, 32'h0000007f);
    quiet <= 1'b0;
    wr(12'h010, 32'hffffffff);
    wait_rd(12'h014, 32'h00000053);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
